// ---- rtl/csd_pkg.sv ----
// constants and carriers for the channel status and divider registers
package csd_pkg;
  localparam int unsigned AW          = 8;
  localparam int unsigned NCH         = 4;
  localparam int unsigned NERR        = 6;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CH3_DIV  = 6'h17;
  localparam logic [5:0] IDX_STATUS   = 6'h18;
  localparam logic [5:0] IDX_ROUTE    = 6'h19;
  localparam logic [5:0] IDX_CONV_CFG = 6'h1c;
  localparam int unsigned IDX_LSB     = 2;
  // divider fields
  localparam int unsigned SIN_LSB     = 12;
  localparam int unsigned SIN_MSB     = 15;
  localparam int unsigned REF_MSB     = 9;
  localparam logic [15:0] DIV_RST     = 16'h0000;
  // status fields; error type i sits at ERR_LSB+i (0 zero count .. 5 under-range)
  localparam int unsigned SRC_LSB     = 14;
  localparam int unsigned ERR_LSB     = 8;
  localparam int unsigned RDY_BIT     = 6;
  // routing: error type i enabled by bit ROUTE_ERR_LSB+i, ready by ROUTE_RDY
  localparam int unsigned ROUTE_ERR_LSB = 2;
  localparam int unsigned ROUTE_RDY   = 0;
  localparam logic [7:0]  ROUTE_WMASK = 8'hfd;
  // conversion sequencing: bit 0 sequential, 2:1 single channel, 7:4 active mask
  localparam int unsigned CFG_SEQ     = 0;
  localparam int unsigned CFG_SEL_LSB = 1;
  localparam int unsigned CFG_ACT_LSB = 4;
  localparam logic [7:0]  CFG_WMASK   = 8'hf7;
  localparam logic [3:0]  MASK_TWO    = 4'h3;
  localparam logic [3:0]  MASK_FOUR   = 4'hf;

  // events from the conversion core, one bit per channel, one-cycle pulses
  typedef struct packed {
    logic [3:0]           done;
    logic [NERR-1:0][3:0] err;
  } csd_evt_s;
endpackage

// ---- rtl/csd_regs.sv ----
// status flag latching and channel three divider register behind apb
`timescale 1ns/1ps
module csd_regs #(
  parameter bit FOUR_CH = 1'b1
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [csd_pkg::AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // conversion core
  input  wire csd_pkg::csd_evt_s ev,
  input  wire logic [3:0]        result_upper_rd,
  output logic [3:0]             ch3_sensor_in_div,
  output logic [9:0]             ch3_ref_div,
  output logic                   ch3_div_invalid,
  // interrupt pin
  output logic                   irq_n_pin
);

  function automatic logic [1:0] first_ch(input logic [3:0] m);
    first_ch = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        first_ch = i[1:0];
      end
    end
  endfunction

  function automatic logic [3:0] rev4(input logic [3:0] v);
    rev4 = {v[0], v[1], v[2], v[3]};
  endfunction

  logic [15:0]           div_r,    div_nxt;
  logic [7:0]            route_r,  route_nxt;
  logic [7:0]            cfg_r,    cfg_nxt;
  logic [csd_pkg::NERR-1:0] err_r, err_nxt;
  logic [1:0]            src_r,    src_nxt;
  logic                  rdy_r,    rdy_nxt;
  logic [3:0]            pend_r,   pend_nxt;
  logic [3:0]            seen_r,   seen_nxt;
  logic [31:0]           prdata_r, prdata_nxt;
  logic                  bad_r,    bad_nxt;
  logic                  irq_n_r,  irq_n_nxt;

  logic [3:0]            chmask;
  logic [3:0]            done;
  logic [3:0]            err_ch;
  logic [csd_pkg::NERR-1:0] hit;
  logic [csd_pkg::NERR-1:0] err_keep;
  logic [5:0]            idx;
  logic                  setup;
  logic                  acc;
  logic                  rd_stat;
  logic                  msb_clr;
  logic                  fresh;
  logic [3:0]            act;
  logic [3:0]            all_seen;
  logic [15:0]           status_word;

  assign chmask = FOUR_CH ? csd_pkg::MASK_FOUR : csd_pkg::MASK_TWO;
  assign idx    = paddr[csd_pkg::AW-1:csd_pkg::IDX_LSB];
  assign setup  = psel & ~penable;
  assign acc    = psel & penable;
  assign done   = ev.done & chmask;
  // read side effects act only on the snapshot already handed out
  assign rd_stat = acc & ~pwrite & ~bad_r & (idx == csd_pkg::IDX_STATUS);
  assign msb_clr = |(result_upper_rd & chmask & (4'h1 << src_r));
  assign act     = cfg_r[csd_pkg::CFG_ACT_LSB +: 4] & chmask;
  assign all_seen = seen_r | done;

  assign status_word = {src_r, err_r, 1'b0, rdy_r, 2'h0, rev4(pend_r)};

  // error latching and source channel
  always_comb begin
    err_ch = 4'h0;
    for (int i = 0; i < csd_pkg::NERR; i++) begin
      hit[i] = (|(ev.err[i] & chmask)) & route_r[csd_pkg::ROUTE_ERR_LSB + i];
      if (hit[i]) begin
        err_ch = err_ch | (ev.err[i] & chmask);
      end
    end
    err_keep = err_r;
    if (rd_stat) begin
      err_keep = err_r & ~prdata_r[csd_pkg::ERR_LSB +: csd_pkg::NERR];
    end
    if (msb_clr) begin
      err_keep = '0;
    end
    err_nxt = err_keep | hit;
    src_nxt = src_r;
    if (err_keep == '0) begin
      src_nxt = (hit != '0) ? first_ch(err_ch) : 2'h0;
    end
  end

  // data ready tracking
  always_comb begin
    if (cfg_r[csd_pkg::CFG_SEQ]) begin
      fresh    = (act != 4'h0) && ((all_seen & act) == act);
      seen_nxt = fresh ? 4'h0 : (all_seen & act);
    end else begin
      fresh    = done[cfg_r[csd_pkg::CFG_SEL_LSB +: 2]];
      seen_nxt = 4'h0;
    end
    rdy_nxt = rdy_r;
    if (rd_stat && prdata_r[csd_pkg::RDY_BIT]) begin
      rdy_nxt = 1'b0;
    end
    if (fresh && route_r[csd_pkg::ROUTE_RDY]) begin
      rdy_nxt = 1'b1;
    end
    pend_nxt  = ((pend_r & ~result_upper_rd) | done) & chmask;
    irq_n_nxt = ~((|err_nxt) | rdy_nxt);
  end

  // apb decode; status has no write path, writes to it are dropped
  always_comb begin
    div_nxt    = div_r;
    route_nxt  = route_r;
    cfg_nxt    = cfg_r;
    prdata_nxt = prdata_r;
    bad_nxt    = bad_r;
    if (setup) begin
      bad_nxt    = 1'b0;
      prdata_nxt = 32'h0;
      if (paddr[csd_pkg::IDX_LSB-1:0] != '0) begin
        bad_nxt = 1'b1;
      end else begin
        case (idx)
          csd_pkg::IDX_CH3_DIV:  prdata_nxt = {16'h0, div_r};
          csd_pkg::IDX_STATUS:   prdata_nxt = {16'h0, status_word};
          csd_pkg::IDX_ROUTE:    prdata_nxt = {24'h0, route_r};
          csd_pkg::IDX_CONV_CFG: prdata_nxt = {24'h0, cfg_r};
          default:               bad_nxt    = 1'b1;
        endcase
      end
    end
    if (acc && pwrite && !bad_r) begin
      case (idx)
        csd_pkg::IDX_CH3_DIV: begin
          // reserved bits 11:10 are stored as written
          if (pstrb[0]) div_nxt[7:0]  = pwdata[7:0];
          if (pstrb[1]) div_nxt[15:8] = pwdata[15:8];
        end
        csd_pkg::IDX_ROUTE: begin
          if (pstrb[0]) route_nxt = pwdata[7:0] & csd_pkg::ROUTE_WMASK;
        end
        csd_pkg::IDX_CONV_CFG: begin
          if (pstrb[0]) cfg_nxt = pwdata[7:0] & csd_pkg::CFG_WMASK;
        end
        default: begin
          div_nxt = div_r;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r    <= csd_pkg::DIV_RST;
      route_r  <= 8'h00;
      cfg_r    <= 8'h00;
      err_r    <= '0;
      src_r    <= 2'h0;
      rdy_r    <= 1'b0;
      pend_r   <= 4'h0;
      seen_r   <= 4'h0;
      prdata_r <= 32'h0;
      bad_r    <= 1'b0;
      irq_n_r  <= 1'b1;
    end else begin
      div_r    <= div_nxt;
      route_r  <= route_nxt;
      cfg_r    <= cfg_nxt;
      err_r    <= err_nxt;
      src_r    <= src_nxt;
      rdy_r    <= rdy_nxt;
      pend_r   <= pend_nxt;
      seen_r   <= seen_nxt;
      prdata_r <= prdata_nxt;
      bad_r    <= bad_nxt;
      irq_n_r  <= irq_n_nxt;
    end
  end

  // zero-wait slave: data was captured in the setup cycle
  assign pready  = acc;
  assign prdata  = prdata_r;
  assign pslverr = acc & bad_r;
  assign irq_n_pin = irq_n_r;
  assign ch3_sensor_in_div = div_r[csd_pkg::SIN_MSB:csd_pkg::SIN_LSB];
  assign ch3_ref_div       = div_r[csd_pkg::REF_MSB:0];
  // zero dividers are reserved; flagged so the core can hold off
  assign ch3_div_invalid   = (ch3_sensor_in_div == 4'h0) | (ch3_ref_div == 10'h0);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zc_latch: assert property (hit[0] |=> err_r[0])
    else $error("zero count error not latched");
  a_al_latch: assert property (hit[1] |=> err_r[1] && irq_n_pin == 1'b0)
    else $error("amplitude low error not latched");
  a_ah_latch: assert property (hit[2] |=> err_r[2])
    else $error("amplitude high error not latched");
  a_wd_hold: assert property (err_r[3] && !rd_stat && !msb_clr |=> err_r[3])
    else $error("watchdog error dropped without a read");
  a_or_route: assert property ($rose(err_r[4]) |-> $past(route_r[csd_pkg::ROUTE_ERR_LSB + 4]))
    else $error("over-range flag set while not routed");
  a_ur_latch: assert property (hit[5] |=> err_r[5])
    else $error("under-range error not latched");
  a_stat_clear: assert property (rd_stat && prdata_r[csd_pkg::ERR_LSB + 3] && !hit[3] |=> !err_r[3])
    else $error("status read did not clear watchdog flag");
  a_msb_clear: assert property (msb_clr && hit == '0 |=> err_r == '0 && src_r == 2'h0)
    else $error("upper result read did not clear errors");
  a_src_name: assert property (err_r == '0 && hit == 6'h01 && ev.err[0] == 4'h2 |=> src_r == 2'h1)
    else $error("wrong source channel");
  a_two_ch: assert property (!FOUR_CH |-> pend_r[3:2] == 2'h0 && !src_r[1])
    else $error("two-channel build shows channel two or three");
  a_pend_set: assert property (done[0] |=> status_word[3])
    else $error("pending flag of channel zero not set");
  a_pend_clr: assert property (result_upper_rd[1] && !done[1] ##1 !done[1] |-> !pend_r[1])
    else $error("pending flag not cleared by upper read");
  a_rdy_gate: assert property ($rose(rdy_r) |-> $past(fresh && route_r[csd_pkg::ROUTE_RDY]))
    else $error("ready set without routed fresh result");
  a_rdy_single: assert property (!cfg_r[0] && done[cfg_r[2:1]] && route_r[0] |=> rdy_r)
    else $error("single mode ready missed");
  a_seq_all: assert property ($rose(rdy_r) && $past(cfg_r[csd_pkg::CFG_SEQ]) |-> $past((all_seen & act) == act))
    else $error("sequential ready before all channels");
  a_div_write: assert property (acc && pwrite && !bad_r && idx == csd_pkg::IDX_CH3_DIV && pstrb[1:0] == 2'h3
                                |=> div_r == $past(pwdata[15:0]))
    else $error("divider write lost");
  a_status_ro: assert property (acc && pwrite && idx == csd_pkg::IDX_STATUS
                                |=> {div_r, route_r, cfg_r} == $past({div_r, route_r, cfg_r}))
    else $error("status write disturbed a register");

  // error flags stay put unless routed, read or cleared by the source upper read
  a_ur_route: assert property (!route_r[csd_pkg::ROUTE_ERR_LSB + 5] && !err_r[5] |=> !err_r[5])
    else $error("unrouted under-range error latched");
  a_ur_gate: assert property ($rose(err_r[5])
                              |-> $past(route_r[csd_pkg::ROUTE_ERR_LSB + 5] && |(ev.err[5] & chmask)))
    else $error("under-range flag set without a routed error");
  a_err_hold: assert property (err_r != '0 && !rd_stat && !msb_clr |=> (err_r & $past(err_r)) == $past(err_r))
    else $error("latched error dropped without a read");
  a_src_hold: assert property (err_r != '0 && !rd_stat && !msb_clr |=> src_r == $past(src_r))
    else $error("source channel changed while an error is latched");
  a_src_clear: assert property (rd_stat && (err_r & ~prdata_r[csd_pkg::ERR_LSB +: csd_pkg::NERR]) == '0
                                && hit == '0 |=> err_r == '0 && src_r == 2'h0)
    else $error("status read left errors or source behind");

  // interrupt pin follows the latched flags one to one
  a_irq_low: assert property (err_r != '0 || rdy_r |-> !irq_n_pin)
    else $error("pin high while a flag is set");
  a_irq_high: assert property (err_r == '0 && !rdy_r |-> irq_n_pin)
    else $error("pin low with no flag set");

  // ready and pending flags
  a_rdy_route: assert property (!route_r[csd_pkg::ROUTE_RDY] && !rdy_r |=> !rdy_r)
    else $error("unrouted ready latched");
  a_rdy_hold: assert property (rdy_r && !rd_stat |=> rdy_r)
    else $error("ready dropped without a status read");
  a_rdy_clear: assert property (rd_stat && prdata_r[csd_pkg::RDY_BIT]
                                && !(fresh && route_r[csd_pkg::ROUTE_RDY]) |=> !rdy_r)
    else $error("status read did not clear ready");
  a_single_only: assert property (!cfg_r[csd_pkg::CFG_SEQ] && !done[cfg_r[csd_pkg::CFG_SEL_LSB +: 2]]
                                  && !rdy_r |=> !rdy_r)
    else $error("single mode ready without a selected result");
  a_seq_wait: assert property (cfg_r[csd_pkg::CFG_SEQ] && (all_seen & act) != act && !rdy_r |=> !rdy_r)
    else $error("sequential ready before all active channels");
  a_pend_hold: assert property (pend_r[2] && !result_upper_rd[2] |=> pend_r[2])
    else $error("pending flag dropped without an upper read");
  a_pend_new: assert property (done[3] |=> pend_r[3] && status_word[0])
    else $error("pending flag of channel three not set");

  // divider only moves on its own write
  a_div_hold: assert property (!(acc && pwrite && !bad_r && idx == csd_pkg::IDX_CH3_DIV)
                               |=> div_r == $past(div_r))
    else $error("divider changed without a write");

endmodule // csd_regs

// ---- test/csd_regs_tb.sv ----
// self-checking apb testbench for the channel status and divider registers
`timescale 1ns/1ps
module csd_regs_tb;
  localparam logic [7:0] A_DIV   = {csd_pkg::IDX_CH3_DIV, 2'b00};
  localparam logic [7:0] A_STAT  = {csd_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] A_ROUTE = {csd_pkg::IDX_ROUTE, 2'b00};
  localparam logic [7:0] A_CFG   = {csd_pkg::IDX_CONV_CFG, 2'b00};
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  logic [31:0]       prdata2;
  csd_pkg::csd_evt_s ev;
  logic [3:0]        result_upper_rd;
  logic [3:0]        ch3_sensor_in_div;
  logic [9:0]        ch3_ref_div;
  logic              ch3_div_invalid;
  logic              irq_n_pin;
  logic [31:0]       rd4;
  logic [31:0]       rd2;
  logic              rerr;
  logic [15:0]       divs [4] = '{16'h2005, 16'hf3ff, 16'h1000, 16'h0001};
  int                err_total = 0;
  int                checks_done = 0;

  csd_regs #(.FOUR_CH(1'b1)) csd_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ev(ev), .result_upper_rd(result_upper_rd), .ch3_sensor_in_div(ch3_sensor_in_div),
    .ch3_ref_div(ch3_ref_div), .ch3_div_invalid(ch3_div_invalid), .irq_n_pin(irq_n_pin));
  // two-channel build shares every input, only its read data is watched
  csd_regs #(.FOUR_CH(1'b0)) csd_regs_inst_two (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(), .prdata(prdata2),
    .pslverr(), .ev(ev), .result_upper_rd(result_upper_rd), .ch3_sensor_in_div(), .ch3_ref_div(),
    .ch3_div_invalid(), .irq_n_pin());

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ends one edge after release so a following transfer never reassigns psel in the same step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd4 = prdata;
    rd2 = prdata2;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input csd_pkg::csd_evt_s e, input logic [3:0] u);
    ev              <= e;
    result_upper_rd <= u;
    @(posedge pclk);
    ev              <= '0;
    result_upper_rd <= 4'h0;
    @(posedge pclk);
  endtask

  // irq pin is registered, so it is looked at away from the launching edge
  task automatic ck_irq(input logic exp);
    @(negedge pclk);
    chk(32'(irq_n_pin), 32'(exp));
    @(posedge pclk);
  endtask

  function automatic csd_pkg::csd_evt_s mk(input int t, input int c, input logic [3:0] d);
    csd_pkg::csd_evt_s e;
    e = '0;
    e.done = d;
    if (t >= 0) e.err[t][c] = 1'b1;
    return e;
  endfunction

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h3;
    ev = '0;
    result_upper_rd = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(ch3_div_invalid), 32'h1);
    xfer(1'b0, A_DIV, 32'h0);
    chk(rd4, 32'h0);
    xfer(1'b1, A_STAT, 32'h0000ffff);
    chk(32'(rerr), 32'h0);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h0);
    xfer(1'b0, 8'h68, 32'h0);
    chk({rd4[30:0], rerr}, 32'h1);
    xfer(1'b0, 8'h5e, 32'h0);
    chk(32'(rerr), 32'h1);
    foreach (divs[k]) begin
      xfer(1'b1, A_DIV, 32'(divs[k]));
      xfer(1'b0, A_DIV, 32'h0);
      chk(rd4, 32'(divs[k]));
      chk(32'({ch3_sensor_in_div, ch3_ref_div}), 32'({divs[k][15:12], divs[k][9:0]}));
      chk(32'(ch3_div_invalid), 32'(divs[k][15:12] == 4'h0 || divs[k][9:0] == 10'h000));
    end
    pstrb <= 4'h1;
    xfer(1'b1, A_DIV, 32'h0000_5a77);
    pstrb <= 4'h2;
    xfer(1'b1, A_DIV, 32'h0000_21ff);
    pstrb <= 4'h3;
    xfer(1'b0, A_DIV, 32'h0);
    chk(rd4, 32'h0000_2177);
    // unrouted error leaves status and pin alone
    pulse(mk(5, 2, 4'h0), 4'h0);
    ck_irq(1'b1);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h0);
    xfer(1'b1, A_ROUTE, 32'hff);
    for (int t = 0; t < 6; t++) begin
      pulse(mk(t, t % 4, 4'h0), 4'h0);
      ck_irq(1'b0);
      xfer(1'b0, A_STAT, 32'h0);
      chk(rd4, (32'h1 << (8 + t)) | (32'(t % 4) << 14));
      ck_irq(1'b1);
      xfer(1'b0, A_STAT, 32'h0);
      chk(rd4, 32'h0);
    end
    // source channel holds and a foreign upper read does not clear
    pulse(mk(3, 2, 4'h0), 4'h0);
    pulse(mk(1, 0, 4'h0), 4'h1);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h0000_8a00);
    pulse(mk(3, 2, 4'h0), 4'h0);
    pulse(mk(-1, 0, 4'h0), 4'h4);
    ck_irq(1'b1);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h0);
    // pending results with ready unrouted
    xfer(1'b1, A_ROUTE, 32'hfc);
    pulse(mk(-1, 0, 4'hf), 4'h0);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h0f);
    pulse(mk(-1, 0, 4'h0), 4'h5);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h05);
    pulse(mk(-1, 0, 4'h0), 4'ha);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h0);
    // ready: single channel one, then sequential over channels zero and two
    xfer(1'b1, A_ROUTE, 32'hfd);
    xfer(1'b1, A_CFG, 32'h22);
    pulse(mk(-1, 0, 4'h2), 4'h0);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h44);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h04);
    xfer(1'b1, A_CFG, 32'h51);
    pulse(mk(-1, 0, 4'h1), 4'h2);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h08);
    pulse(mk(-1, 0, 4'h4), 4'h0);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h4a);
    pulse(mk(-1, 0, 4'h0), 4'h5);
    xfer(1'b1, A_CFG, 32'h22);
    // upper channels are invisible to the two-channel build
    pulse(mk(0, 3, 4'hc), 4'h0);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd4, 32'h0000_c103);
    chk(rd2, 32'h0);
    pulse(mk(0, 1, 4'h0), 4'h0);
    xfer(1'b0, A_STAT, 32'h0);
    chk(rd2, 32'h0000_4100);
    chk(rd4, 32'h0000_4103);
    final_report();
  end

  initial begin
    repeat (4000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule // csd_regs_tb
